// File: rtl/ppwr_pkg.sv
// constants for the port police and wred register bank
package ppwr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets (word aligned)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_PTR   = 8'h04;
	localparam logic [7:0] OFF_CTRL  = 8'h0C;
	localparam logic [7:0] OFF_RATE  = 8'h20;
	localparam logic [7:0] OFF_BURST = 8'h24;
	localparam logic [7:0] OFF_PMTHR = 8'h30;
	localparam logic [7:0] OFF_PMMUL = 8'h34;
	localparam logic [7:0] OFF_QTHR  = 8'h40;
	localparam logic [7:0] OFF_QMUL  = 8'h44;
	localparam logic [7:0] OFF_CMON  = 8'h50;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PTR_PORT_LSB  = 16;
	localparam int PTR_QUEUE_LSB = 0;
	localparam int CTL_DROPPED   = 11;
	localparam int CTL_DROPALL   = 10;
	localparam int CTL_PTYPE_LSB = 8;
	localparam int CTL_PORTPOL   = 7;
	localparam int CTL_NONIP_LSB = 5;
	localparam int CTL_MARK      = 4;
	localparam int CTL_REMAP     = 3;
	localparam int CTL_DROPSRP   = 2;
	localparam int CTL_BLIND     = 1;
	localparam int CTL_ENABLE    = 0;
	localparam int HI_LSB        = 16;
	localparam int LO_LSB        = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] RST_CTRL  = 12'h020;
	localparam logic [15:0] RST_CIR   = 16'h1000;
	localparam logic [15:0] RST_PIR   = 16'h2000;
	localparam logic [15:0] RST_CBS   = 16'h1000;
	localparam logic [15:0] RST_PBS   = 16'h3000;
	localparam logic [10:0] RST_PMMAX = 11'h400;
	localparam logic [10:0] RST_PMMIN = 11'h080;
	localparam logic [10:0] RST_PMMUL = 11'h020;
	localparam logic [10:0] RST_QMAX  = 11'h080;
	localparam logic [10:0] RST_QMIN  = 11'h009;
	localparam logic [10:0] RST_QMUL  = 11'h010;
	localparam logic [21:0] RST_LFSR  = 22'h000001;

	// ----------------------------------------------------------------
	// colour and monitor packet type codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CLR_DROPPED = 2'h0;
	localparam logic [1:0] CLR_GREEN   = 2'h1;
	localparam logic [1:0] CLR_YELLOW  = 2'h2;
	localparam logic [1:0] CLR_RED     = 2'h3;

endpackage

// File: rtl/ppwr_wred_drop.sv
// one level of weighted random early detection drop decision
`timescale 1ns/1ps
`default_nettype none

module ppwr_wred_drop (
	input  wire logic [10:0] avg,
	input  wire logic [10:0] min_thr,
	input  wire logic [10:0] max_thr,
	input  wire logic [10:0] mult,
	input  wire logic [21:0] rnd,
	input  wire logic        drop_all,
	output logic             drop
);
	logic [10:0] over;
	logic [21:0] prob;

	// probability grows with distance above the minimum
	assign over = avg - min_thr;
	assign prob = {11'h000, over} * {11'h000, mult};

	always_comb begin
		if (avg < min_thr) begin
			drop = 1'b0;
		end else if (avg > max_thr && drop_all) begin
			drop = 1'b1;
		end else begin
			drop = (rnd < prob);
		end
	end
endmodule // ppwr_wred_drop

`default_nettype wire

// File: rtl/ppwr_colour_pick.sv
// ingress colour selection for the policer
`timescale 1ns/1ps
`default_nettype none

module ppwr_colour_pick (
	input  wire logic       enable,
	input  wire logic       blind,
	input  wire logic       is_ip,
	input  wire logic [1:0] non_ip_frame_colour,
	input  wire logic       remap_en,
	input  wire logic [1:0] dscp_clr,
	input  wire logic [1:0] remap_clr,
	output logic [1:0]      colour
);
	// blind or disabled policing starts every frame green
	always_comb begin
		if (!enable || blind) begin
			colour = ppwr_pkg::CLR_GREEN;
		end else if (!is_ip) begin
			colour = non_ip_frame_colour;
		end else if (remap_en) begin
			colour = remap_clr;
		end else begin
			colour = dscp_clr;
		end
	end
endmodule // ppwr_colour_pick

`default_nettype wire

// File: rtl/ppwr_regbank.sv
// port police and wred configuration bank with wishbone slave
// Behaviour
// - pointer bits 18:16 pick one of seven ports for indexed fields
// - pointer bits 1:0 pick one of four queues for indexed fields
// - control bit 11 set: colour counter counts only dropped packets
// - control bit 10 set: drop all above packet memory maximum
// - bits 9:8 choose counter read: red, yellow, green or dropped
// - bit 7 clear: policing per queue using port zero rates
// - colour aware non ip frames take bits 6:5 colour, default 01
// - bit 4 enables dscp colour marking
// - bit 3 set remaps dscp colour, clear uses it unchanged
// - bit 2 clear exempts reservation packets from wred drops
// - bit 1 set colour blind, clear colour aware
// - bit 0 enables policing and wred, resets disabled
// - committed rate in rate bits 31:16, reset 0x1000
// - peak rate in rate bits 15:0, reset 0x2000
// - committed burst bytes in burst bits 31:16, reset 0x1000
// - peak burst bytes in burst bits 15:0, reset 0x3000
// - packet memory max and min thresholds, reset 0x400 and 0x080
// - packet memory probability multiplier bits 26:16, reset 0x020
// - packet memory average size read only in bits 10:0
// - queue max and min thresholds, reset 0x080 and 0x009
// - queue probability multiplier bits 26:16, reset 0x010
// - queue average size read only in bits 10:0
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ppwr_regbank #(
	parameter int NPORT  = 7,
	parameter int NQUEUE = 4,
	parameter int CNT_W  = 24
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic [31:0]      DAT_O,
	output logic             ACK_O,
	input  wire logic        PKT_VALID,
	input  wire logic [2:0]  PKT_PORT,
	input  wire logic [1:0]  PKT_QUEUE,
	input  wire logic        PKT_IS_IP,
	input  wire logic        PKT_SRP,
	input  wire logic [1:0]  PKT_DSCP_CLR,
	input  wire logic [1:0]  PKT_REMAP_CLR,
	input  wire logic [10:0] PKT_QAVG,
	input  wire logic [10:0] PM_AVG,
	input  wire logic [10:0] SEL_QAVG,
	output logic [2:0]       SEL_PORT,
	output logic [1:0]       SEL_QUEUE,
	output logic             PKT_DONE,
	output logic             PKT_DROP,
	output logic [1:0]       PKT_COLOUR,
	output logic             PKT_MARK,
	output logic             POL_EN,
	output logic [15:0]      POL_CIR,
	output logic [15:0]      POL_PIR,
	output logic [15:0]      POL_CBS,
	output logic [15:0]      POL_PBS
);
	localparam int NENT = NPORT * NQUEUE;
	localparam int IW   = $clog2(NENT);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// flat table index of one port and queue pair
	function automatic logic [IW-1:0] ent_idx(input logic [2:0] p,
			input logic [1:0] q);
		return IW'(int'(p) * NQUEUE + int'(q));
	endfunction

	// byte lane merge of a write onto an old word
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	// word address match against a byte offset
	function automatic logic hit(input logic [7:0] adr,
			input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [2:0]        port_r;
	logic [1:0]        queue_r;
	logic [11:0]       ctrl_r;
	logic [15:0]       cir_r [NENT];
	logic [15:0]       pir_r [NENT];
	logic [15:0]       cbs_r [NENT];
	logic [15:0]       pbs_r [NENT];
	logic [10:0]       qmax_r [NENT];
	logic [10:0]       qmin_r [NENT];
	logic [10:0]       qmul_r [NENT];
	logic [CNT_W-1:0]  cnt_r [NENT][4];
	logic [10:0]       pmmax_r;
	logic [10:0]       pmmin_r;
	logic [10:0]       pmmul_r;
	logic [21:0]       lfsr_r;

	logic              req;
	logic              wr;
	logic              sel_ok;
	logic [IW-1:0]     sel_idx;
	logic [31:0]       rd_nxt;
	logic [31:0]       wword;
	logic [31:0]       old_word;

	logic              pkt_ok;
	logic [IW-1:0]     pkt_idx;
	logic [IW-1:0]     pol_idx;
	logic              pm_drop;
	logic              q_drop;
	logic              drop_nxt;
	logic [1:0]        clr_nxt;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one wait state: request seen, ack next edge, then dropped
	assign req     = CYC_I & STB_I & ~ACK_O;
	assign wr      = req & WE_I;
	assign sel_ok  = int'(port_r) < NPORT;
	assign sel_idx = sel_ok ? ent_idx(port_r, queue_r) : '0;

	// current stored word at the addressed slot, for lane merging
	always_comb begin
		old_word = 32'h0000_0000;
		if (hit(ADR_I, ppwr_pkg::OFF_PTR)) begin
			old_word = {13'h0000, port_r, 14'h0000, queue_r};
		end else if (hit(ADR_I, ppwr_pkg::OFF_CTRL)) begin
			old_word = {20'h00000, ctrl_r};
		end else if (hit(ADR_I, ppwr_pkg::OFF_RATE)) begin
			old_word = {cir_r[sel_idx], pir_r[sel_idx]};
		end else if (hit(ADR_I, ppwr_pkg::OFF_BURST)) begin
			old_word = {cbs_r[sel_idx], pbs_r[sel_idx]};
		end else if (hit(ADR_I, ppwr_pkg::OFF_PMTHR)) begin
			old_word = {5'h00, pmmax_r, 5'h00, pmmin_r};
		end else if (hit(ADR_I, ppwr_pkg::OFF_PMMUL)) begin
			old_word = {5'h00, pmmul_r, 16'h0000};
		end else if (hit(ADR_I, ppwr_pkg::OFF_QTHR)) begin
			old_word = {5'h00, qmax_r[sel_idx], 5'h00, qmin_r[sel_idx]};
		end else if (hit(ADR_I, ppwr_pkg::OFF_QMUL)) begin
			old_word = {5'h00, qmul_r[sel_idx], 16'h0000};
		end
	end

	assign wword = lane_merge(old_word, DAT_I, SEL_I);

	// read data; reserved bits and unmapped words return zero
	always_comb begin
		rd_nxt = old_word;
		if (hit(ADR_I, ppwr_pkg::OFF_PMMUL)) begin
			rd_nxt = {5'h00, pmmul_r, 5'h00, PM_AVG};
		end else if (hit(ADR_I, ppwr_pkg::OFF_QMUL)) begin
			rd_nxt = {5'h00, qmul_r[sel_idx], 5'h00, SEL_QAVG};
		end else if (hit(ADR_I, ppwr_pkg::OFF_CMON)) begin
			rd_nxt = {{(32-CNT_W){1'b0}},
				cnt_r[sel_idx][ctrl_r[ppwr_pkg::CTL_PTYPE_LSB +: 2]]};
		end
		if (!sel_ok && !hit(ADR_I, ppwr_pkg::OFF_PTR) &&
				!hit(ADR_I, ppwr_pkg::OFF_CTRL) &&
				!hit(ADR_I, ppwr_pkg::OFF_PMTHR) &&
				!hit(ADR_I, ppwr_pkg::OFF_PMMUL)) begin
			rd_nxt = 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// ack and data come together from flops
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= req;
			DAT_O <= (req && !WE_I) ? rd_nxt : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// direct registers
	// ----------------------------------------------------------------
	// pointer, control and packet memory thresholds
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			port_r  <= 3'h0;
			queue_r <= 2'h0;
			ctrl_r  <= ppwr_pkg::RST_CTRL;
			pmmax_r <= ppwr_pkg::RST_PMMAX;
			pmmin_r <= ppwr_pkg::RST_PMMIN;
			pmmul_r <= ppwr_pkg::RST_PMMUL;
		end else if (wr) begin
			if (hit(ADR_I, ppwr_pkg::OFF_PTR)) begin
				port_r  <= wword[ppwr_pkg::PTR_PORT_LSB +: 3];
				queue_r <= wword[ppwr_pkg::PTR_QUEUE_LSB +: 2];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_CTRL)) begin
				ctrl_r <= wword[11:0];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_PMTHR)) begin
				pmmax_r <= wword[ppwr_pkg::HI_LSB +: 11];
				pmmin_r <= wword[ppwr_pkg::LO_LSB +: 11];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_PMMUL)) begin
				pmmul_r <= wword[ppwr_pkg::HI_LSB +: 11];
			end
		end
	end

	// ----------------------------------------------------------------
	// indexed per port and queue tables
	// ----------------------------------------------------------------
	// writes to a port index beyond the last port are dropped
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int i = 0; i < NENT; i++) begin
				cir_r[i]  <= ppwr_pkg::RST_CIR;
				pir_r[i]  <= ppwr_pkg::RST_PIR;
				cbs_r[i]  <= ppwr_pkg::RST_CBS;
				pbs_r[i]  <= ppwr_pkg::RST_PBS;
				qmax_r[i] <= ppwr_pkg::RST_QMAX;
				qmin_r[i] <= ppwr_pkg::RST_QMIN;
				qmul_r[i] <= ppwr_pkg::RST_QMUL;
			end
		end else if (wr && sel_ok) begin
			if (hit(ADR_I, ppwr_pkg::OFF_RATE)) begin
				cir_r[sel_idx] <= wword[ppwr_pkg::HI_LSB +: 16];
				pir_r[sel_idx] <= wword[ppwr_pkg::LO_LSB +: 16];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_BURST)) begin
				cbs_r[sel_idx] <= wword[ppwr_pkg::HI_LSB +: 16];
				pbs_r[sel_idx] <= wword[ppwr_pkg::LO_LSB +: 16];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_QTHR)) begin
				qmax_r[sel_idx] <= wword[ppwr_pkg::HI_LSB +: 11];
				qmin_r[sel_idx] <= wword[ppwr_pkg::LO_LSB +: 11];
			end
			if (hit(ADR_I, ppwr_pkg::OFF_QMUL)) begin
				qmul_r[sel_idx] <= wword[ppwr_pkg::HI_LSB +: 11];
			end
		end
	end

	// ----------------------------------------------------------------
	// random source for probabilistic drops
	// ----------------------------------------------------------------
	// maximal 22 bit lfsr, free running
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lfsr_r <= ppwr_pkg::RST_LFSR;
		end else begin
			lfsr_r <= {lfsr_r[20:0], lfsr_r[21] ^ lfsr_r[20]};
		end
	end

	// ----------------------------------------------------------------
	// packet decision
	// ----------------------------------------------------------------
	assign pkt_ok  = PKT_VALID && (int'(PKT_PORT) < NPORT);
	assign pkt_idx = pkt_ok ? ent_idx(PKT_PORT, PKT_QUEUE) : '0;
	// per queue uses port zero rates
	assign pol_idx = ctrl_r[ppwr_pkg::CTL_PORTPOL] ? pkt_idx :
		ent_idx(3'h0, PKT_QUEUE);

	// shared packet memory level
	ppwr_wred_drop u_pm_drop (
		.avg      (PM_AVG),
		.min_thr  (pmmin_r),
		.max_thr  (pmmax_r),
		.mult     (pmmul_r),
		.rnd      (lfsr_r),
		.drop_all (ctrl_r[ppwr_pkg::CTL_DROPALL]),
		.drop     (pm_drop)
	);

	// per queue level
	ppwr_wred_drop u_q_drop (
		.avg      (PKT_QAVG),
		.min_thr  (qmin_r[pkt_idx]),
		.max_thr  (qmax_r[pkt_idx]),
		.mult     (qmul_r[pkt_idx]),
		.rnd      (lfsr_r),
		.drop_all (ctrl_r[ppwr_pkg::CTL_DROPALL]),
		.drop     (q_drop)
	);

	ppwr_colour_pick u_colour (
		.enable              (ctrl_r[ppwr_pkg::CTL_ENABLE]),
		.blind               (ctrl_r[ppwr_pkg::CTL_BLIND]),
		.is_ip               (PKT_IS_IP),
		.non_ip_frame_colour (ctrl_r[ppwr_pkg::CTL_NONIP_LSB +: 2]),
		.remap_en            (ctrl_r[ppwr_pkg::CTL_REMAP]),
		.dscp_clr            (PKT_DSCP_CLR),
		.remap_clr           (PKT_REMAP_CLR),
		.colour              (clr_nxt)
	);

	assign drop_nxt = pkt_ok && ctrl_r[ppwr_pkg::CTL_ENABLE] &&
		!(PKT_SRP && !ctrl_r[ppwr_pkg::CTL_DROPSRP]) &&
		(pm_drop || q_drop);

	// verdict and policer settings, one cycle after the packet
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PKT_DONE   <= 1'b0;
			PKT_DROP   <= 1'b0;
			PKT_COLOUR <= ppwr_pkg::CLR_GREEN;
			PKT_MARK   <= 1'b0;
			POL_EN     <= 1'b0;
			POL_CIR    <= ppwr_pkg::RST_CIR;
			POL_PIR    <= ppwr_pkg::RST_PIR;
			POL_CBS    <= ppwr_pkg::RST_CBS;
			POL_PBS    <= ppwr_pkg::RST_PBS;
		end else begin
			PKT_DONE <= pkt_ok;
			PKT_DROP <= drop_nxt;
			POL_EN   <= ctrl_r[ppwr_pkg::CTL_ENABLE];
			if (pkt_ok) begin
				PKT_COLOUR <= clr_nxt;
				PKT_MARK   <= ctrl_r[ppwr_pkg::CTL_ENABLE] &
					ctrl_r[ppwr_pkg::CTL_MARK];
				POL_CIR    <= cir_r[pol_idx];
				POL_PIR    <= pir_r[pol_idx];
				POL_CBS    <= cbs_r[pol_idx];
				POL_PBS    <= pbs_r[pol_idx];
			end
		end
	end

	// selected entry shown to the datapath for average lookup
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SEL_PORT  <= 3'h0;
			SEL_QUEUE <= 2'h0;
		end else begin
			SEL_PORT  <= port_r;
			SEL_QUEUE <= queue_r;
		end
	end

	// ----------------------------------------------------------------
	// colour monitor counters
	// ----------------------------------------------------------------
	// counters wrap; software samples differences
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int i = 0; i < NENT; i++) begin
				for (int k = 0; k < 4; k++) begin
					cnt_r[i][k] <= '0;
				end
			end
		end else if (pkt_ok) begin
			if (drop_nxt) begin
				cnt_r[pkt_idx][ppwr_pkg::CLR_DROPPED] <=
					cnt_r[pkt_idx][ppwr_pkg::CLR_DROPPED] + 1'b1;
			end
			if (clr_nxt != ppwr_pkg::CLR_DROPPED &&
					(drop_nxt || !ctrl_r[ppwr_pkg::CTL_DROPPED])) begin
				cnt_r[pkt_idx][clr_nxt] <= cnt_r[pkt_idx][clr_nxt] + 1'b1;
			end
		end
	end
endmodule // ppwr_regbank

`default_nettype wire

// File: dv/ppwr_regbank_sva.sv
// assertions on the port police and wred register bank ports
`timescale 1ns/1ps
`default_nettype none

module ppwr_regbank_sva (
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [7:0]  ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	input wire logic        PKT_VALID,
	input wire logic [2:0]  PKT_PORT,
	input wire logic        PKT_DONE,
	input wire logic        PKT_DROP,
	input wire logic [1:0]  PKT_COLOUR,
	input wire logic        PKT_MARK,
	input wire logic        POL_EN
);
	// ----------------------------------------------------------------
	// bus handshake and packet decision timing
	// ----------------------------------------------------------------
	// one clock domain, so one clocking and one disable for all
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// a taken request is answered exactly one edge later
	a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("bus request not acknowledged on next edge");
	a_ack_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("acknowledge longer than one cycle");
	// read data is zero outside the acknowledge cycle
	a_rd_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
		else $error("read data not zero without acknowledge");
	a_resv_zero: assert property (ACK_O && !WE_I &&
		(ADR_I == ppwr_pkg::OFF_PMTHR || ADR_I == ppwr_pkg::OFF_QTHR)
		|-> DAT_O[31:27] == 5'h0 && DAT_O[15:11] == 5'h0)
		else $error("reserved threshold bits read non-zero");
	a_done_valid: assert property (
		PKT_VALID && PKT_PORT != 3'h7 |=> PKT_DONE)
		else $error("packet on valid port got no decision");
	// a decision only follows a request on one of the seven ports
	a_done_cause: assert property (PKT_DONE |->
		$past(PKT_VALID) && $past(PKT_PORT) != 3'h7)
		else $error("decision without a valid packet request");
	a_off_quiet: assert property (PKT_DONE && !POL_EN |->
		!PKT_DROP && !PKT_MARK && PKT_COLOUR == ppwr_pkg::CLR_GREEN)
		else $error("disabled policing still acted on packet");
	a_mark_gate: assert property (PKT_DONE && PKT_MARK |-> POL_EN)
		else $error("colour marking while disabled");
	a_drop_done: assert property (PKT_DROP |-> PKT_DONE)
		else $error("drop flag outside decision cycle");
endmodule // ppwr_regbank_sva

bind ppwr_regbank ppwr_regbank_sva u_sva (.REF_CLK(REF_CLK), .RST(RST),
	.CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .PKT_VALID(PKT_VALID),
	.PKT_PORT(PKT_PORT), .PKT_DONE(PKT_DONE), .PKT_DROP(PKT_DROP),
	.PKT_COLOUR(PKT_COLOUR), .PKT_MARK(PKT_MARK), .POL_EN(POL_EN));

`default_nettype wire

// File: dv/ppwr_regbank_tb_top.sv
// self-checking bench for the port police and wred register bank
`timescale 1ns/1ps
`default_nettype none

module ppwr_regbank_tb_top;
	// ----------------------------------------------------------------
	// stimulus signals and bookkeeping
	// ----------------------------------------------------------------
	logic        REF_CLK = 1'b0, RST = 1'b1;
	logic        CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
	logic [7:0]  ADR_I = 8'h00;
	logic [3:0]  SEL_I = 4'h0;
	logic [31:0] DAT_I = 32'h0, DAT_O, d;
	logic        ACK_O, PKT_VALID = 1'b0, PKT_IS_IP = 1'b0, PKT_SRP = 1'b0;
	logic [2:0]  PKT_PORT = 3'h0, SEL_PORT;
	logic [1:0]  PKT_QUEUE = 2'h0, PKT_DSCP_CLR = 2'h0, SEL_QUEUE;
	logic [1:0]  PKT_REMAP_CLR = 2'h2, PKT_COLOUR;
	logic [10:0] PKT_QAVG = 11'h000, PM_AVG = 11'h055, SEL_QAVG = 11'h2AA;
	logic        PKT_DONE, PKT_DROP, PKT_MARK, POL_EN;
	logic [15:0] POL_CIR, POL_PIR, POL_CBS, POL_PBS;
	int          bad_count = 0, n_checks = 0;
	localparam logic [7:0] A_PTR = ppwr_pkg::OFF_PTR;
	localparam logic [7:0] A_CTL = ppwr_pkg::OFF_CTRL;
	localparam logic [7:0] A_RATE = ppwr_pkg::OFF_RATE;
	localparam logic [7:0] A_CMON = ppwr_pkg::OFF_CMON;
	// all-ones writes; pointer lands on port 7 so indexed reads give zero
	localparam logic [7:0] RA [7] = '{A_PTR, A_CTL, ppwr_pkg::OFF_PMTHR,
		ppwr_pkg::OFF_PMMUL, A_RATE, ppwr_pkg::OFF_QMUL, 8'hFC};
	localparam logic [31:0] RE [7] = '{32'h00070003, 32'h00000FFF,
		32'h07FF07FF, 32'h07FF0055, 32'h0, 32'h0, 32'h0};

	always #12.5 REF_CLK = ~REF_CLK;

	ppwr_regbank uut (.REF_CLK(REF_CLK), .RST(RST), .CYC_I(CYC_I),
		.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
		.DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PKT_VALID(PKT_VALID),
		.PKT_PORT(PKT_PORT), .PKT_QUEUE(PKT_QUEUE), .PKT_IS_IP(PKT_IS_IP),
		.PKT_SRP(PKT_SRP), .PKT_DSCP_CLR(PKT_DSCP_CLR),
		.PKT_REMAP_CLR(PKT_REMAP_CLR), .PKT_QAVG(PKT_QAVG), .PM_AVG(PM_AVG),
		.SEL_QAVG(SEL_QAVG), .SEL_PORT(SEL_PORT), .SEL_QUEUE(SEL_QUEUE),
		.PKT_DONE(PKT_DONE), .PKT_DROP(PKT_DROP), .PKT_COLOUR(PKT_COLOUR),
		.PKT_MARK(PKT_MARK), .POL_EN(POL_EN), .POL_CIR(POL_CIR),
		.POL_PIR(POL_PIR), .POL_CBS(POL_CBS), .POL_PBS(POL_PBS));

	// ----------------------------------------------------------------
	// tasks: compare, wishbone cycle, packet request, verdict
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string w);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h exp %h", $time, w, got, exp);
			bad_count++;
		end
	endtask

	// classic cycle; waits on ack with no bound of its own, the
	// watchdog alone ends a hung wait so it cannot pass silently
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] wd, output logic [31:0] q);
		@(posedge REF_CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= a;
		SEL_I <= s;
		DAT_I <= wd;
		do @(posedge REF_CLK); while (ACK_O !== 1'b1);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] q;
		wb(1'b1, a, 4'hF, wd, q);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string w);
		logic [31:0] q;
		wb(1'b0, a, 4'hF, 32'h0, q);
		chk(q, e, w);
	endtask

	// f = {ip, reservation}; e = {drop, mark, colour}
	task automatic pkt(input logic [2:0] p, input logic [1:0] q, f, dc,
		input logic [10:0] qa, input logic [3:0] e);
		@(posedge REF_CLK);
		PKT_VALID <= 1'b1;
		PKT_PORT <= p;
		PKT_QUEUE <= q;
		PKT_IS_IP <= f[1];
		PKT_SRP <= f[0];
		PKT_DSCP_CLR <= dc;
		PKT_QAVG <= qa;
		@(posedge REF_CLK);
		PKT_VALID <= 1'b0;
		#1;
		chk({31'h0, PKT_DONE}, {31'h0, p != 3'h7}, "decision flag");
		if (p != 3'h7)
			chk({PKT_DROP, PKT_MARK, PKT_COLOUR}, e, "decision");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog: whole run needs well under two thousand cycles
	initial begin
		#(25 * 5000);
		bad_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge REF_CLK);
		RST <= 1'b0;
		rc(A_CTL, 32'h020, "ctrl reset");
		rc(A_RATE, 32'h10002000, "rate reset");
		rc(ppwr_pkg::OFF_BURST, 32'h10003000, "burst reset");
		rc(ppwr_pkg::OFF_PMTHR, 32'h04000080, "pm thr reset");
		rc(ppwr_pkg::OFF_PMMUL, 32'h00200055, "pm mul reset");
		rc(ppwr_pkg::OFF_QTHR, 32'h00800009, "q thr reset");
		rc(ppwr_pkg::OFF_QMUL, 32'h001002AA, "q mul reset");
		for (int i = 0; i < 7; i++) begin
			wr(RA[i], 32'hFFFFFFFF);
			rc(RA[i], RE[i], "all ones");
		end
		// indexed storage: port 2 queue 3, partial byte lanes
		wr(A_PTR, 32'h00020003);
		wr(A_RATE, 32'hAAAA5555);
		wb(1'b1, ppwr_pkg::OFF_BURST, 4'h3, 32'hFFFF5678, d);
		chk({27'h0, SEL_PORT, SEL_QUEUE}, 32'h0B, "sel copy");
		wr(A_PTR, 32'h00010003);
		rc(A_RATE, 32'h10002000, "other port");
		wr(A_PTR, 32'h00020002);
		rc(A_RATE, 32'h10002000, "other queue");
		wr(A_PTR, 32'h00020003);
		rc(A_RATE, 32'hAAAA5555, "rate kept");
		rc(ppwr_pkg::OFF_BURST, 32'h10005678, "burst lanes");
		// colour, marking, enable and drop decisions
		wr(A_CTL, 32'h412);
		pkt(3'h4, 2'h0, 2'b10, 2'h3, 11'h7FF, 4'b0001);
		wr(A_CTL, 32'h013);
		pkt(3'h4, 2'h0, 2'b10, 2'h3, 11'h000, 4'b0101);
		wr(A_CTL, 32'h001);
		pkt(3'h4, 2'h0, 2'b10, 2'h3, 11'h000, 4'b0011);
		wr(A_CTL, 32'h009);
		pkt(3'h4, 2'h0, 2'b10, 2'h3, 11'h000, 4'b0010);
		for (int c = 0; c < 4; c++) begin
			wr(A_CTL, 32'h001 | (c << 5));
			pkt(3'h4, 2'h1, 2'b00, 2'h3, 11'h000, 4'(c));
		end
		wr(A_CTL, 32'h403);
		pkt(3'h4, 2'h0, 2'b01, 2'h0, 11'h7FF, 4'b0001);
		pkt(3'h4, 2'h0, 2'b00, 2'h0, 11'h008, 4'b0001);
		pkt(3'h7, 2'h0, 2'b00, 2'h0, 11'h000, 4'b0000);
		wr(A_CTL, 32'h407);
		pkt(3'h4, 2'h0, 2'b01, 2'h0, 11'h7FF, 4'b1001);
		// aggregate rates under port zero versus per-port rates
		wr(A_PTR, 32'h00000001);
		wr(A_RATE, 32'h11112222);
		wr(A_PTR, 32'h00030001);
		wr(A_RATE, 32'h33334444);
		wr(A_CTL, 32'h001);
		pkt(3'h3, 2'h1, 2'b10, 2'h1, 11'h000, 4'b0001);
		chk({POL_CIR, POL_PIR}, 32'h11112222, "aggregate rate");
		chk({POL_CBS, POL_PBS}, 32'h10003000, "burst out");
		wr(A_CTL, 32'h081);
		pkt(3'h3, 2'h1, 2'b10, 2'h1, 11'h000, 4'b0001);
		chk({POL_CIR, POL_PIR}, 32'h33334444, "port rate");
		// colour counters of port 5 queue 2, all then dropped-only
		wr(A_CTL, 32'h403);
		pkt(3'h5, 2'h2, 2'b00, 2'h0, 11'h000, 4'b0001);
		pkt(3'h5, 2'h2, 2'b00, 2'h0, 11'h000, 4'b0001);
		pkt(3'h5, 2'h2, 2'b00, 2'h0, 11'h7FF, 4'b1001);
		wr(A_PTR, 32'h00050002);
		wr(A_CTL, 32'h503);
		rc(A_CMON, 32'h3, "green all");
		wr(A_CTL, 32'h403);
		rc(A_CMON, 32'h1, "dropped");
		wr(A_CTL, 32'hC03);
		pkt(3'h5, 2'h2, 2'b00, 2'h0, 11'h000, 4'b0001);
		pkt(3'h5, 2'h2, 2'b00, 2'h0, 11'h7FF, 4'b1001);
		rc(A_CMON, 32'h2, "dropped again");
		for (int t = 1; t < 4; t++) begin
			wr(A_CTL, 32'hC03 | (t << 8));
			rc(A_CMON, (t == 1) ? 32'h4 : 32'h0, "colour count");
		end
		end_sim();
	end
endmodule // ppwr_regbank_tb_top

`default_nettype wire
